// ===== ohci_revision_control_regs.sv
`include "ohci_regs_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module ohci_revision_control_regs #(
	parameter int FUNC_INDEX = 0,
	parameter int SPACE_BITS = 12,
	parameter int SOF_START_CYCLES =
		`HCI_SOF_START_US * `HCI_CLK_MHZ
) (
	// Clock and hardware reset.
	input wire logic sys_clk,
	input wire logic sys_rst,

	// Software reset pulse from the command logic.
	input wire logic softReset,

	// Base address from the configuration space.
	input wire logic [31:0] barBase,

	// Memory access from the PCI target.
	input wire ohci_regs_pkg::mem_req_t memReq,
	output logic memHit,
	output logic memAck,
	output logic [31:0] memRdata,

	// Status events from the rest of the controller.
	input wire logic eventIrq,
	input wire logic resumeStatus,
	input wire logic resumeDetected,

	// Interrupt and wake-up outputs.
	output logic hostIrq,
	output logic smiIrq,
	output logic remoteWake,

	// Control towards the list engines and root hub.
	output ohci_regs_pkg::ctrl_t ctrl,
	output logic sofEnable,
	output logic rootHubReset,
	output logic downstreamReset
);

	localparam int CNT_W = $clog2(SOF_START_CYCLES + 1);

	// Parameter values that the version word, the decode and the frame counter cannot serve stop elaboration.
	if (FUNC_INDEX < 0 || FUNC_INDEX > 1) begin : gBadFuncIndex
		$error("FUNC_INDEX must be 0 or 1.");
	end
	if (SPACE_BITS < 3 || SPACE_BITS > 31) begin : gBadSpaceBits
		$error("SPACE_BITS must be 3 to 31.");
	end
	if (SOF_START_CYCLES < 1) begin : gBadSofStart
		$error("SOF_START_CYCLES must be positive.");
	end

	// A word offset matches when the in-space address equals it.
	function automatic logic isReg(
		input logic [31:0] addr,
		input logic [11:0] ofs
	);
		logic [31:0] wide;
		wide = {20'h00000, ofs};
		isReg = (addr[SPACE_BITS-1:2] == wide[SPACE_BITS-1:2]);
	endfunction : isReg

	logic inSpace;
	logic hitVersion;
	logic hitControl;
	logic ctrlWrite;
	logic [31:0] laneMask;
	logic [31:0] ctrlWord;
	logic [31:0] versionWord;
	logic [31:0] mergedWord;

	ohci_regs_pkg::ctrl_t next_ctrl;
	logic next_memAck;
	logic [31:0] next_memRdata;
	logic [CNT_W-1:0] sofCount;
	logic [CNT_W-1:0] next_sofCount;
	logic next_sofEnable;
	logic next_rootHubReset;
	logic hwResetSeen;
	logic next_hwResetSeen;

	// Address decode against the programmed base.
	always_comb begin
		inSpace = (memReq.addr[31:SPACE_BITS] == barBase[31:SPACE_BITS]);
		memHit = memReq.req && inSpace;
		hitVersion = isReg(memReq.addr, `HCI_OFS_VERSION);
		hitControl = isReg(memReq.addr, `HCI_OFS_CONTROL);
		ctrlWrite = memHit && memReq.write && hitControl;
	end

	// Byte lanes of a write.
	for (genvar lane = 0; lane < 4; lane++) begin : gLane
		assign laneMask[lane*8 +: 8] = {8{memReq.byteEn[lane]}};
	end

	always_comb begin
		versionWord = `HCI_ZERO_WORD;
		versionWord[`HCI_REV_MSB:`HCI_REV_LSB] = `HCI_REV_BCD;
		versionWord[`HCI_LEGACY_BIT] = (FUNC_INDEX == 0);
	end

	// Reserved control bits are not stored and read as zero.
	always_comb begin
		ctrlWord = `HCI_ZERO_WORD;
		ctrlWord[`HCI_WAKE_EN_BIT] = ctrl.remote_wake_enable;
		ctrlWord[`HCI_CONN_BIT] = ctrl.remote_wake_connected;
		ctrlWord[`HCI_ROUTE_BIT] = ctrl.smi_route_select;
		ctrlWord[`HCI_FSTATE_MSB:`HCI_FSTATE_LSB] =
			ctrl.functional_state;
		ctrlWord[`HCI_BULK_BIT] = ctrl.bulk_list_on;
		ctrlWord[`HCI_CTRL_LIST_BIT] = ctrl.ctrl_list_on;
		ctrlWord[`HCI_ISO_BIT] = ctrl.iso_list_on;
		ctrlWord[`HCI_PERIODIC_BIT] = ctrl.periodic_list_on;
		ctrlWord[`HCI_RATIO_MSB:`HCI_RATIO_LSB] = ctrl.ctrl_bulk_ratio;
		mergedWord = (ctrlWord & ~laneMask) | (memReq.wdata & laneMask);
	end

	// Read path: one-cycle registered answer, no side effects.
	always_comb begin
		next_memAck = memHit;
		next_memRdata = memRdata;
		if (memHit && !memReq.write) begin
			if (hitVersion) begin
				next_memRdata = versionWord;
			end else if (hitControl) begin
				next_memRdata = ctrlWord;
			end else begin
				next_memRdata = `HCI_ZERO_WORD;
			end
		end
	end

	// Control fields.
	always_comb begin
		next_ctrl = ctrl;
		if (softReset) begin
			// Connected and routing bits survive a soft reset.
			next_ctrl.remote_wake_enable = 1'b0;
			next_ctrl.functional_state = ohci_regs_pkg::state_sleep;
			next_ctrl.bulk_list_on = 1'b0;
			next_ctrl.ctrl_list_on = 1'b0;
			next_ctrl.iso_list_on = 1'b0;
			next_ctrl.periodic_list_on = 1'b0;
			next_ctrl.ctrl_bulk_ratio = `HCI_RATIO_RST;
		end else begin
			if (ctrlWrite) begin
				next_ctrl.remote_wake_enable =
					mergedWord[`HCI_WAKE_EN_BIT];
				next_ctrl.remote_wake_connected =
					mergedWord[`HCI_CONN_BIT];
				next_ctrl.smi_route_select =
					mergedWord[`HCI_ROUTE_BIT];
				next_ctrl.functional_state = ohci_regs_pkg::func_state_t'(
					mergedWord[`HCI_FSTATE_MSB:`HCI_FSTATE_LSB]);
				next_ctrl.bulk_list_on = mergedWord[`HCI_BULK_BIT];
				next_ctrl.ctrl_list_on = mergedWord[`HCI_CTRL_LIST_BIT];
				next_ctrl.iso_list_on = mergedWord[`HCI_ISO_BIT];
				next_ctrl.periodic_list_on =
					mergedWord[`HCI_PERIODIC_BIT];
				next_ctrl.ctrl_bulk_ratio =
					mergedWord[`HCI_RATIO_MSB:`HCI_RATIO_LSB];
			end
			// A resume seen while sleeping is never lost to a write.
			case (ctrl.functional_state)
				ohci_regs_pkg::state_sleep: begin
					if (resumeDetected) begin
						next_ctrl.functional_state =
							ohci_regs_pkg::state_wake;
					end
				end
				ohci_regs_pkg::state_bus_reset,
				ohci_regs_pkg::state_wake,
				ohci_regs_pkg::state_running: begin
				end
				default: begin
					next_ctrl.functional_state = ohci_regs_pkg::state_bus_reset;
				end
			endcase
		end
	end

	// Frame generation starts a fixed time after entering running.
	always_comb begin
		next_sofCount = sofCount;
		next_sofEnable = sofEnable;
		// The wait is counted from the first cycle in running, so the entry cycle reloads.
		// Rewriting running while already running leaves the count alone.
		if (next_ctrl.functional_state != ohci_regs_pkg::state_running ||
			ctrl.functional_state != ohci_regs_pkg::state_running) begin
			next_sofCount = CNT_W'(SOF_START_CYCLES);
			next_sofEnable = 1'b0;
		end else if (sofCount != '0) begin
			next_sofCount = sofCount - CNT_W'(1);
			next_sofEnable = (sofCount == CNT_W'(1));
		end
	end

	// The hub reset is held through hardware reset and for one cycle after its release.
	always_comb begin
		next_hwResetSeen = 1'b1;
		next_rootHubReset = !hwResetSeen;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl <= '0;
			memAck <= 1'b0;
			memRdata <= `HCI_ZERO_WORD;
			sofCount <= CNT_W'(SOF_START_CYCLES);
			sofEnable <= 1'b0;
			hwResetSeen <= 1'b0;
			rootHubReset <= 1'b1;
		end else begin
			ctrl <= next_ctrl;
			memAck <= next_memAck;
			memRdata <= next_memRdata;
			sofCount <= next_sofCount;
			sofEnable <= next_sofEnable;
			hwResetSeen <= next_hwResetSeen;
			rootHubReset <= next_rootHubReset;
		end
	end

	// Interrupt routing never looks at the wake enable.
	always_comb begin
		hostIrq = eventIrq && !ctrl.smi_route_select;
		smiIrq = eventIrq && ctrl.smi_route_select;
		remoteWake = ctrl.remote_wake_enable && resumeStatus;
		downstreamReset =
			(ctrl.functional_state == ohci_regs_pkg::state_bus_reset);
	end

endmodule : ohci_revision_control_regs

`default_nettype wire

// ===== ohci_regs_defines.svh
`ifndef OHCI_REGS_DEFINES_SVH
`define OHCI_REGS_DEFINES_SVH

// Byte offsets inside the memory space of one function.
`define HCI_OFS_VERSION 12'h000
`define HCI_OFS_CONTROL 12'h004

// Configuration offset that holds the base address.
`define HCI_CFG_BAR_OFS 8'h10

// Version register layout.
`define HCI_REV_BCD 8'h10
`define HCI_REV_LSB 0
`define HCI_REV_MSB 7
`define HCI_LEGACY_BIT 8

// Control register layout.
`define HCI_RATIO_LSB 0
`define HCI_RATIO_MSB 1
`define HCI_PERIODIC_BIT 2
`define HCI_ISO_BIT 3
`define HCI_CTRL_LIST_BIT 4
`define HCI_BULK_BIT 5
`define HCI_FSTATE_LSB 6
`define HCI_FSTATE_MSB 7
`define HCI_ROUTE_BIT 8
`define HCI_CONN_BIT 9
`define HCI_WAKE_EN_BIT 10

// Reset values of the stored fields.
`define HCI_RATIO_RST 2'h0
`define HCI_ZERO_WORD 32'h0000_0000

// Timing.
`define HCI_CLK_MHZ 200
`define HCI_SOF_START_US 1000

`endif

// ===== ohci_regs_pkg.sv
package ohci_regs_pkg;

	// Encodings are fixed by software; they count in plain binary, and wake to running flips both bits.
	typedef enum logic [1:0] {
		state_bus_reset = 2'h0,
		state_wake = 2'h1,
		state_running = 2'h2,
		state_sleep = 2'h3
	} func_state_t;

	typedef struct packed {
		logic remote_wake_enable;
		logic remote_wake_connected;
		logic smi_route_select;
		func_state_t functional_state;
		logic bulk_list_on;
		logic ctrl_list_on;
		logic iso_list_on;
		logic periodic_list_on;
		logic [1:0] ctrl_bulk_ratio;
	} ctrl_t;

	typedef struct packed {
		logic req;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] byteEn;
	} mem_req_t;

endpackage : ohci_regs_pkg

// ===== ohci_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ohci_host_model (
	input wire logic sys_clk,
	input wire logic memAck,
	input wire logic [31:0] memRdata,
	output ohci_regs_pkg::mem_req_t memReq
);
	initial memReq = '0;
	// A request lasts one cycle; released lines show the inverted arguments, and control write data is driven with bits 31:11 cleared.
	task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q,
		output logic ok);
		@(posedge sys_clk);
		#1 memReq = '{1'b1, w, a, a[11:2] == 1 ? d & 32'h0000_07ff : d, 4'hf};
		@(posedge sys_clk);
		#1 ok = memAck;
		q = memRdata;
		memReq = '{1'b0, ~w, ~a, ~d, 4'h0};
	endtask : xfer
endmodule : ohci_host_model
`default_nettype wire

// ===== ohci_regs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ohci_regs_sva #(
	parameter int FUNC_INDEX = 0,
	parameter int SPACE_BITS = 12,
	parameter int SOF_START_CYCLES = 8
) (
	input wire logic sys_clk, sys_rst, softReset,
	input wire logic [31:0] barBase,
	input wire ohci_regs_pkg::mem_req_t memReq,
	input wire logic memHit, memAck,
	input wire logic [31:0] memRdata,
	input wire logic eventIrq, resumeStatus, resumeDetected, hostIrq, smiIrq, remoteWake,
	input wire ohci_regs_pkg::ctrl_t ctrl,
	input wire logic sofEnable, rootHubReset, downstreamReset
);
	wire logic rdHit = memHit && !memReq.write;
	wire logic running = ctrl.functional_state == ohci_regs_pkg::state_running;
	wire logic asleep = ctrl.functional_state == ohci_regs_pkg::state_sleep;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	ack_next_a: assert property (memAck == $past(memHit)) else $error("bad ack");
	version_word_a: assert property (rdHit && memReq.addr[SPACE_BITS-1:2] == 0 |=>
		memRdata == {23'h0, FUNC_INDEX == 0, 8'h10}) else $error("bad version");
	control_word_a: assert property (rdHit && memReq.addr[SPACE_BITS-1:2] == 1 |=>
		memRdata == {21'h0, $past(ctrl)}) else $error("bad control read");
	irq_wake_a: assert property ({hostIrq, smiIrq, remoteWake} == {eventIrq && !ctrl[8],
		eventIrq && ctrl[8], ctrl[10] && resumeStatus}) else $error("bad irq or wake");
	fields_hold_a: assert property (!(memHit && memReq.write) && !softReset |=>
		$stable({ctrl[10:8], ctrl[5:0]})) else $error("field moved");
	soft_reset_a: assert property (softReset |=> asleep && ctrl[9:8] == $past(ctrl[9:8]))
		else $error("bad soft reset");
	resume_move_a: assert property (asleep && resumeDetected && !softReset |=>
		ctrl.functional_state == ohci_regs_pkg::state_wake) else $error("no resume");
	hw_reset_a: assert property ($fell(sys_rst) |-> ctrl == '0 && downstreamReset && rootHubReset)
		else $error("bad reset state");
	sof_start_a: assert property ($rose(sofEnable) |-> $past(running, SOF_START_CYCLES) &&
		!$past(running, SOF_START_CYCLES + 1)) else $error("bad frame start");
	cover property (remoteWake);
	cover property (smiIrq);
	cover property ($rose(sofEnable));
endmodule : ohci_regs_sva
bind ohci_revision_control_regs ohci_regs_sva #(.FUNC_INDEX(FUNC_INDEX), .SPACE_BITS(SPACE_BITS),
	.SOF_START_CYCLES(SOF_START_CYCLES)) chk (.*);
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int N = 8;
	localparam logic [31:0] B0 = 32'h8000_0000;
	localparam logic [31:0] C0 = 32'h8000_0004;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic softReset = 1'b0, eventIrq = 1'b0, resumeStatus = 1'b0, resumeDetected = 1'b0;
	logic [1:0] ack, hIrq, sIrq, wake, sof, rhr, dsr;
	logic [31:0] q;
	logic [31:0] rdata [2];
	logic ok;
	ohci_regs_pkg::mem_req_t memReq;
	int errors, checks_done, cycles;
	ohci_host_model host (.sys_clk(sys_clk), .memAck(|ack),
		.memRdata(ack[1] ? rdata[1] : rdata[0]), .memReq(memReq));
	// Both functions share one request bus; only the addressed one answers.
	for (genvar i = 0; i < 2; i++) begin : fn
		ohci_revision_control_regs #(.FUNC_INDEX(i), .SOF_START_CYCLES(N)) uut (.sys_clk(sys_clk),
			.sys_rst(sys_rst), .softReset(softReset), .barBase(B0 + i * 32'h1000),
			.memReq(memReq), .memHit(), .memAck(ack[i]), .memRdata(rdata[i]),
			.eventIrq(eventIrq), .resumeStatus(resumeStatus), .resumeDetected(resumeDetected),
			.hostIrq(hIrq[i]), .smiIrq(sIrq[i]), .remoteWake(wake[i]), .ctrl(),
			.sofEnable(sof[i]), .rootHubReset(rhr[i]), .downstreamReset(dsr[i]));
	end
	initial forever #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			wrap_up();
		end
	end
	task automatic check(input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic rd(input logic [31:0] a, exp);
		host.xfer(1'b0, a, 32'h0, q, ok);
		check(q, exp);
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic wrap_up();
		$display("checks %0d, errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		tick(2);
		sys_rst = 1'b0;
		for (int i = 0; i < 2; i++) begin
			rd(B0 + i * 32'h1000, {23'h0, i == 0, 8'h10});
			rd(C0 + i * 32'h1000, 32'h0);
		end
		host.xfer(1'b1, B0, 32'hffff_ffff, q, ok);
		rd(B0, 32'h0000_0110);
		rd(B0 + 32'h8, 32'h0);
		host.xfer(1'b0, 32'h4000_0004, 32'h0, q, ok);
		check({31'h0, ok}, 32'h0);
		$display("reset and decode test done");
		eventIrq = 1'b1;
		resumeStatus = 1'b1;
		host.xfer(1'b1, C0, 32'hffff_f6ff, q, ok);
		check({29'h0, hIrq[0], sIrq[0], wake[0]}, 32'h5);
		host.xfer(1'b1, C0, 32'h0000_0100, q, ok);
		check({29'h0, hIrq[0], sIrq[0], wake[0]}, 32'h2);
		host.xfer(1'b1, C0, 32'h0000_07ff, q, ok);
		tick(3);
		rd(C0, 32'h0000_07ff);
		$display("control test done");
		softReset = 1'b1;
		tick(1);
		softReset = 1'b0;
		rd(C0, 32'h0000_03c0);
		resumeDetected = 1'b1;
		tick(1);
		resumeDetected = 1'b0;
		rd(C0, 32'h0000_0340);
		host.xfer(1'b1, C0, 32'h0000_0380, q, ok);
		tick(N - 1);
		check({31'h0, sof[0]}, 32'h0);
		tick(1);
		check({31'h0, sof[0]}, 32'h1);
		$display("state test done");
		sys_rst = 1'b1;
		tick(2);
		check({30'h0, rhr[0], dsr[0]}, 32'h3);
		sys_rst = 1'b0;
		rd(C0, 32'h0);
		check({31'h0, rhr[0]}, 32'h0);
		$display("hardware reset test done");
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
